// [rtl/cmd_gate_pkg.sv]
// Purpose: shared types and constants for the remote/local command gate
// Assumes: one 10 MHz clock, synchronous active-low reset
// Notes:   command classes arrive pre-decoded from the parser
package cmd_gate_pkg;

   typedef enum logic [1:0] {
      ST_LOCAL,
      ST_LOCAL_LOCKOUT,
      ST_REMOTE,
      ST_REMOTE_LOCKOUT
   } rl_state_t;

   // pre-decoded command descriptor
   typedef struct packed {
      logic       is_query;
      logic       is_calcomp;
      logic       is_protected;
      logic       is_stb_query;
      logic [7:0] opcode;
   } cmd_desc_t;

   // bus interface messages, one-cycle pulses
   typedef struct packed {
      logic mla;
      logic gtl;
      logic llo;
      logic spoll;
      logic cls;
   } bus_msg_t;

   localparam int  RESP_W         = 8;
   localparam int  QUEUE_DEPTH    = 8;
   localparam int  QUEUE_AW       = 3;
   localparam int  SRE_W          = 8;
   localparam logic [7:0] SRE_RESET   = 8'h00;
   localparam logic [7:0] ERR_PROTECT = 8'h5a;
   localparam logic [7:0] ERR_REJECT  = 8'h5b;
   localparam logic [7:0] ERR_NONE    = 8'h00;
   localparam logic [7:0] STB_SUM_MSK = 8'h3e;
   localparam int  STB_SAV        = 1;
   localparam int  STB_ISCB       = 2;
   localparam int  STB_EAV        = 3;
   localparam int  STB_MAV        = 4;
   localparam int  STB_ESB        = 5;
   localparam int  STB_RQS        = 6;

endpackage

// [rtl/remote_local_command_gate.sv]
// Purpose: command acceptance, remote/local state, response queue, STB
// Assumes: commands arrive pre-decoded, one per handshake, same clock;
//          bus messages are one-cycle pulses; pins except PANEL_KEY_I are synchronised here
// Notes:   a command is taken only once the previous one is done, so order is preserved
//
// Contract
// [R1] execute commands in arrival order, each finished before next starts
// [R2] in local, reject calibration and compensation commands incl. mem fix
// [R3] in listen-only, reject cal/comp commands and all queries
// [R4] protected commands run only with protect switch 1, else log error
// [R5] local accepts front panel and remote commands except restricted ones
// [R6] local-lockout plus remote command goes to remote-lockout
// [R7] REN asserted and listen address enters remote
// [R8] remote indicator lit while in a remote state
// [R9] in remote, only clear/local key acts; it returns to local
// [R10] go-to-local in remote returns to local
// [R11] remote-lockout entered only from remote or local-lockout
// [R12] in remote-lockout clear/local key shows lockout message, no change
// [R13] go-to-local in remote-lockout goes to local-lockout
// [R14] LLO with REN adds lockout; REN low drops to plain local
// [R15] query responses queue and leave first-in first-out per read
// [R16] empty queue on read sends no response
// [R17] each status source has an enabled summary bit in the status byte
// [R18] SRQ asserted while any enabled status condition is active; code sets it on an enabled rise and drops it on poll or clear
// [R19] status byte returned on serial poll and on its query
// [R20] at power-up status byte derives from the stored enable register
`timescale 1ns/100ps
module remote_local_command_gate
   import cmd_gate_pkg::*;
#(
   parameter int DEPTH_AW = QUEUE_AW
) (
   input  wire logic              CLK_I,
   input  wire logic              RESETN_I,
   input  wire logic              REN_I,
   input  wire logic              PROTECT_SW_I,
   input  wire logic              LISTEN_ONLY_I,
   input  wire logic              CLEAR_LOCAL_KEY_I,
   input  wire logic              PANEL_KEY_I,
   input  wire bus_msg_t          BUS_MSG_I,
   input  wire logic              CMD_VALID_I,
   input  wire cmd_desc_t         CMD_I,
   output logic                   CMD_READY_O,
   output logic                   EXEC_VALID_O,
   output logic [7:0]             EXEC_OPCODE_O,
   input  wire logic              EXEC_DONE_I,
   input  wire logic              RESP_VALID_I,
   input  wire logic [RESP_W-1:0] RESP_DATA_I,
   input  wire logic              READ_REQ_I,
   output logic                   READ_VALID_O,
   output logic [RESP_W-1:0]      READ_DATA_O,
   input  wire logic [7:0]        SRE_NV_I,
   input  wire logic              SRE_WR_I,
   input  wire logic [7:0]        SRE_DATA_I,
   input  wire logic              ESB_I,
   input  wire logic              EAV_I,
   input  wire logic              ISCB_I,
   input  wire logic              SAV_I,
   output logic                   ERR_PUSH_O,
   output logic [7:0]             ERR_CODE_O,
   output logic                   PANEL_ACCEPT_O,
   output logic                   REMOTE_LED_O,
   output logic                   LOCKOUT_MSG_O,
   output logic [7:0]             STB_O,
   output logic                   SRQ_O
);

   ////////////////////////////////////////////////////////////////////
   // pin synchronisers; first stage feeds only the second
   logic [3:0] pin_meta_r;
   logic [3:0] pin_sync_r;
   logic       ren;
   logic       protect_sw;
   logic       listen_only;
   logic       key_lvl;
   logic       key_prev_r;
   logic       key_press;

   always_ff @(posedge CLK_I) begin
      if (!RESETN_I) begin
         pin_meta_r <= 4'h0;
         pin_sync_r <= 4'h0;
      end else begin
         pin_meta_r <= {CLEAR_LOCAL_KEY_I, LISTEN_ONLY_I,
                        PROTECT_SW_I, REN_I};
         pin_sync_r <= pin_meta_r;
      end
   end

   assign ren         = pin_sync_r[0];
   assign protect_sw  = pin_sync_r[1];
   assign listen_only = pin_sync_r[2];
   assign key_lvl     = pin_sync_r[3];

   always_ff @(posedge CLK_I) begin
      if (!RESETN_I) begin
         key_prev_r <= 1'b0;
      end else begin
         key_prev_r <= key_lvl;
      end
   end

   assign key_press = key_lvl & ~key_prev_r;

   ////////////////////////////////////////////////////////////////////
   // remote/local state
   rl_state_t state_r;
   rl_state_t state_nxt;
   logic      remote_cmd;

   // a listen address or any taken command counts as a remote command
   assign remote_cmd = BUS_MSG_I.mla | (CMD_VALID_I & CMD_READY_O);

   always_comb begin
      state_nxt = state_r;
      if (!ren) begin
         state_nxt = ST_LOCAL; // [R14]
      end else begin
         unique case (state_r)
            ST_LOCAL: begin
               if (BUS_MSG_I.llo) begin
                  state_nxt = ST_LOCAL_LOCKOUT; // [R14]
               end else if (BUS_MSG_I.mla) begin
                  state_nxt = ST_REMOTE; // [R7] [R11]
               end
            end
            ST_LOCAL_LOCKOUT: begin
               if (remote_cmd) begin
                  state_nxt = ST_REMOTE_LOCKOUT; // [R6]
               end
            end
            ST_REMOTE: begin
               if (BUS_MSG_I.llo) begin
                  state_nxt = ST_REMOTE_LOCKOUT; // [R11]
               end else if (BUS_MSG_I.gtl || key_press) begin
                  state_nxt = ST_LOCAL; // [R9] [R10]
               end
            end
            ST_REMOTE_LOCKOUT: begin
               if (BUS_MSG_I.gtl) begin
                  state_nxt = ST_LOCAL_LOCKOUT; // [R13]
               end
            end
         endcase
      end
   end

   always_ff @(posedge CLK_I) begin
      if (!RESETN_I) begin
         state_r <= ST_LOCAL;
      end else begin
         state_r <= state_nxt;
      end
   end

   logic is_remote;
   assign is_remote = (state_r == ST_REMOTE) ||
                      (state_r == ST_REMOTE_LOCKOUT);

   always_ff @(posedge CLK_I) begin
      if (!RESETN_I) begin
         REMOTE_LED_O   <= 1'b0;
         LOCKOUT_MSG_O  <= 1'b0;
         PANEL_ACCEPT_O <= 1'b0;
      end else begin
         REMOTE_LED_O   <= is_remote; // [R8]
         LOCKOUT_MSG_O  <= (state_r == ST_REMOTE_LOCKOUT) & key_press; // [R12]
         PANEL_ACCEPT_O <= PANEL_KEY_I & ~is_remote; // [R5] [R9]
      end
   end

   ////////////////////////////////////////////////////////////////////
   // command gate: one command in flight at a time
   logic       busy_r;
   logic       reject;
   logic       protect_fail;
   logic       is_local;
   logic       take;
   logic       stb_query_r;

   assign is_local = (state_r == ST_LOCAL) ||
                     (state_r == ST_LOCAL_LOCKOUT);
   assign reject = (is_local & CMD_I.is_calcomp) |               // [R2]
                   (listen_only & (CMD_I.is_calcomp | CMD_I.is_query)); // [R3]
   assign protect_fail = CMD_I.is_protected & ~protect_sw; // [R4]

   // stall while a command runs, so the next cannot start early
   assign CMD_READY_O = ~busy_r; // [R1]
   assign take        = CMD_VALID_I & CMD_READY_O;

   always_ff @(posedge CLK_I) begin
      if (!RESETN_I) begin
         busy_r        <= 1'b0;
         EXEC_VALID_O  <= 1'b0;
         EXEC_OPCODE_O <= 8'h00;
      end else if (take && !reject && !protect_fail
                   && !CMD_I.is_stb_query) begin
         busy_r        <= 1'b1; // [R1]
         EXEC_VALID_O  <= 1'b1;
         EXEC_OPCODE_O <= CMD_I.opcode;
      end else if (busy_r && EXEC_DONE_I) begin
         busy_r       <= 1'b0; // [R1]
         EXEC_VALID_O <= 1'b0;
      end
   end

   always_ff @(posedge CLK_I) begin
      if (!RESETN_I) begin
         ERR_PUSH_O <= 1'b0;
         ERR_CODE_O <= ERR_NONE;
      end else begin
         ERR_PUSH_O <= take & (reject | protect_fail);
         ERR_CODE_O <= reject ? ERR_REJECT :
                       (protect_fail ? ERR_PROTECT : ERR_NONE); // [R4]
      end
   end

   // status-byte query answers from the gate itself
   always_ff @(posedge CLK_I) begin
      if (!RESETN_I) begin
         stb_query_r <= 1'b0;
      end else begin
         stb_query_r <= take & CMD_I.is_stb_query & ~reject; // [R19]
      end
   end

   ////////////////////////////////////////////////////////////////////
   // output queue; full queue drops further responses
   logic [DEPTH_AW:0]   wptr_r;
   logic [DEPTH_AW:0]   rptr_r;
   logic                q_empty;
   logic                q_full;
   logic                push;
   logic                pop;
   logic [RESP_W-1:0]   push_data;
   logic [RESP_W-1:0]   mem_rdata;
   logic                pop_d_r;

   assign q_empty   = (wptr_r == rptr_r);
   assign q_full    = (wptr_r[DEPTH_AW] != rptr_r[DEPTH_AW]) &&
                      (wptr_r[DEPTH_AW-1:0] == rptr_r[DEPTH_AW-1:0]);
   assign push      = (RESP_VALID_I | stb_query_r) & ~q_full; // [R15]
   assign push_data = stb_query_r ? STB_O : RESP_DATA_I; // [R19]
   assign pop       = READ_REQ_I & ~q_empty; // [R16]

   always_ff @(posedge CLK_I) begin
      if (!RESETN_I) begin
         wptr_r <= '0;
         rptr_r <= '0;
      end else begin
         if (push) begin
            wptr_r <= wptr_r + 1'b1;
         end
         if (pop) begin
            rptr_r <= rptr_r + 1'b1; // [R15]
         end
      end
   end

   resp_mem #(
      .W  (RESP_W),
      .AW (DEPTH_AW)
   ) u_mem (
      .clk_i   (CLK_I),
      .we_i    (push),
      .waddr_i (wptr_r[DEPTH_AW-1:0]),
      .wdata_i (push_data),
      .raddr_i (rptr_r[DEPTH_AW-1:0]),
      .rdata_o (mem_rdata)
   );

   always_ff @(posedge CLK_I) begin
      if (!RESETN_I) begin
         pop_d_r <= 1'b0;
      end else begin
         pop_d_r <= pop;
      end
   end

   assign READ_VALID_O = pop_d_r; // [R16]
   assign READ_DATA_O  = mem_rdata;

   ////////////////////////////////////////////////////////////////////
   // service request enable: loaded from storage at reset release
   logic [SRE_W-1:0] sre_r;
   logic             load_pend_r;

   always_ff @(posedge CLK_I) begin
      if (!RESETN_I) begin
         load_pend_r <= 1'b1;
         sre_r       <= SRE_RESET;
      end else if (load_pend_r) begin
         load_pend_r <= 1'b0;
         sre_r       <= SRE_NV_I; // [R20]
      end else if (SRE_WR_I) begin
         sre_r <= SRE_DATA_I;
      end
   end

   stb_summary u_stb (
      .clk_i      (CLK_I),
      .resetn_i   (RESETN_I),
      .sre_i      (sre_r),
      .esb_i      (ESB_I),
      .mav_i      (~q_empty),
      .eav_i      (EAV_I),
      .iscb_i     (ISCB_I),
      .sav_i      (SAV_I),
      .poll_clr_i (BUS_MSG_I.spoll | BUS_MSG_I.cls), // [R19]
      .stb_o      (STB_O),
      .srq_o      (SRQ_O)
   );

endmodule

// [rtl/resp_mem.sv]
// Purpose: small response store with registered read data
// Assumes: single clock, one write and one read port
// Notes:   no reset on the array; contents are only read once written
`timescale 1ns/100ps
module resp_mem
   import cmd_gate_pkg::*;
#(
   parameter int W  = RESP_W,
   parameter int AW = QUEUE_AW
) (
   input  wire logic          clk_i,
   input  wire logic          we_i,
   input  wire logic [AW-1:0] waddr_i,
   input  wire logic [W-1:0]  wdata_i,
   input  wire logic [AW-1:0] raddr_i,
   output logic      [W-1:0]  rdata_o
);

   logic [W-1:0] mem_r [2**AW];

   always_ff @(posedge clk_i) begin
      if (we_i) begin
         mem_r[waddr_i] <= wdata_i;
      end
   end

   always_ff @(posedge clk_i) begin
      rdata_o <= mem_r[raddr_i];
   end

endmodule

// [rtl/stb_summary.sv]
// Purpose: serial poll status byte and service request
// Assumes: condition bits are levels on the same clock
// Notes:   rqs rises on an enabled 0-to-1 change of a summary bit
`timescale 1ns/100ps
module stb_summary
   import cmd_gate_pkg::*;
(
   input  wire logic       clk_i,
   input  wire logic       resetn_i,
   input  wire logic [7:0] sre_i,
   input  wire logic       esb_i,
   input  wire logic       mav_i,
   input  wire logic       eav_i,
   input  wire logic       iscb_i,
   input  wire logic       sav_i,
   input  wire logic       poll_clr_i,
   output logic      [7:0] stb_o,
   output logic            srq_o
);

   logic [7:0] cond;
   logic [7:0] cond_prev_r;
   logic       mss;
   logic       rqs_r;

   always_comb begin
      cond           = 8'h00;
      cond[STB_SAV]  = sav_i;
      cond[STB_ISCB] = iscb_i;
      cond[STB_EAV]  = eav_i;
      cond[STB_MAV]  = mav_i;
      cond[STB_ESB]  = esb_i;
   end

   assign mss = |(cond & sre_i & STB_SUM_MSK); // [R17]

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         cond_prev_r <= 8'h00;
      end else begin
         cond_prev_r <= cond;
      end
   end

   // a new enabled rise wins over a poll clear in the same cycle
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         rqs_r <= 1'b0;
      end else if (|(cond & ~cond_prev_r & sre_i & STB_SUM_MSK)) begin
         rqs_r <= 1'b1; // [R18]
      end else if (poll_clr_i || !mss) begin
         rqs_r <= 1'b0;
      end
   end

   // status byte is recomputed from the conditions every cycle; only its
   // rqs bit uses sre, so only rqs reflects the restored enable value
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         stb_o <= 8'h00;
      end else begin
         stb_o          <= cond; // [R20]
         stb_o[STB_RQS] <= rqs_r | (|(cond & ~cond_prev_r & sre_i
                                      & STB_SUM_MSK));
      end
   end

   assign srq_o = rqs_r; // [R18]

endmodule

// [verif/exec_model.sv]
// Purpose: command executor standing behind the gate
// Assumes: one command at a time, done is a one-cycle pulse
// Notes:   dly_i sets how slow the answer is, 0 answers at once
`timescale 1ns/100ps
module exec_model (
   input  wire logic       clk_i,
   input  wire logic       valid_i,
   input  wire logic [3:0] dly_i,
   output logic            done_o
);
   logic [3:0] cnt_r;

   initial begin
      done_o = 1'b0;
      cnt_r  = 4'h0;
   end

   ////////////////////////////////////////
   // finish only what was started; the done pulse is never repeated
   always @(negedge clk_i) begin
      done_o <= 1'b0;
      if (valid_i && !done_o && cnt_r >= dly_i) begin
         done_o <= 1'b1;
         cnt_r  <= 4'h0;
      end else if (valid_i && !done_o) begin
         cnt_r <= cnt_r + 4'h1;
      end
   end
endmodule

// [verif/remote_local_command_gate_tb.sv]
// Purpose: self-checking bench for the command gate
// Assumes: inputs change on the falling edge
// Notes:   command words are {query,calcomp,protected,stb,opcode}
`timescale 1ns/100ps
module remote_local_command_gate_tb
   import cmd_gate_pkg::*;
;
   localparam bus_msg_t M_MLA = 5'h10;
   localparam bus_msg_t M_GTL = 5'h08;
   localparam bus_msg_t M_LLO = 5'h04;
   localparam bus_msg_t M_SPL = 5'h02;
   logic clk, resetn, ren, prot, lonly, key_r, pk, cvld, rvld, rreq, sre_wr;
   logic eav, rdy, xvld, done, rdv, err, pacc, led, lkmsg, srq, lk_seen;
   logic esb, iscb, sav;
   logic [7:0] xop, rdat, rdd, ecode, stb, sre_dat;
   logic [3:0] dly;
   bus_msg_t   msg;
   cmd_desc_t  cmd;
   int         fails, n_compared;

   remote_local_command_gate DUT (.CLK_I(clk), .RESETN_I(resetn),
      .REN_I(ren), .PROTECT_SW_I(prot), .LISTEN_ONLY_I(lonly),
      .CLEAR_LOCAL_KEY_I(key_r), .PANEL_KEY_I(pk), .BUS_MSG_I(msg),
      .CMD_VALID_I(cvld), .CMD_I(cmd), .CMD_READY_O(rdy),
      .EXEC_VALID_O(xvld), .EXEC_OPCODE_O(xop), .EXEC_DONE_I(done),
      .RESP_VALID_I(rvld), .RESP_DATA_I(rdat), .READ_REQ_I(rreq),
      .READ_VALID_O(rdv), .READ_DATA_O(rdd), .SRE_NV_I(8'h08),
      .SRE_WR_I(sre_wr), .SRE_DATA_I(sre_dat), .ESB_I(esb), .EAV_I(eav),
      .ISCB_I(iscb), .SAV_I(sav), .ERR_PUSH_O(err), .ERR_CODE_O(ecode),
      .PANEL_ACCEPT_O(pacc), .REMOTE_LED_O(led), .LOCKOUT_MSG_O(lkmsg),
      .STB_O(stb), .SRQ_O(srq));
   exec_model partner (.clk_i(clk), .valid_i(xvld), .dly_i(dly),
      .done_o(done));

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // the message is a one-cycle pulse, so latch it for later checking
   always @(posedge clk) if (lkmsg) lk_seen <= 1'b1;

   ////////////////////////////////////////
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         fails++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic tally_and_finish;
      $display("compared=%0d mismatches=%0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic bus(input bus_msg_t m);
      msg = m;
      cyc(1);
      msg = '0;
      cyc(3);
   endtask
   task automatic press;
      key_r = 1'b1;
      cyc(5);
      key_r = 1'b0;
      cyc(5);
   endtask
   task automatic send(input cmd_desc_t d, input logic [7:0] e);
      int n;
      n = 0;
      cmd = d;
      cvld = 1'b1;
      // ready is settled at the falling edge, so the next rise takes it
      while (!rdy && n < 50) begin
         n++;
         cyc(1);
      end
      cyc(1);
      cvld = 1'b0;
      check(err, e != 8'h00);
      check(xvld, e == 8'h00 && !d.is_stb_query);
      if (e != 8'h00) begin
         check(ecode, e);
      end else if (!d.is_stb_query) begin
         check(xop, d.opcode);
      end
      cyc(1);
   endtask
   task automatic rd(input logic v, input logic [7:0] d);
      rreq = 1'b1;
      cyc(1);
      rreq = 1'b0;
      check(rdv, v);
      if (v) begin
         check(rdd, d);
      end
      cyc(1);
   endtask

   ////////////////////////////////////////
   task automatic t_states;
      pk = 1'b1;
      cyc(2);
      check(pacc, 1);
      bus(M_MLA);
      check(led, 1);
      check(pacc, 0);
      bus(M_GTL);
      check(led, 0);
      bus(M_MLA);
      press();
      check(led, 0);
      check(lk_seen, 0);
      bus(M_LLO);
      check(led, 0);
      bus(M_MLA);
      check(led, 1);
      press();
      check(led, 1);
      check(lk_seen, 1);
      bus(M_GTL);
      check(led, 0);
      send(12'h011, 8'h00);
      cyc(4);
      check(led, 1);
      ren = 1'b0;
      cyc(5);
      check(led, 0);
      ren = 1'b1;
      pk = 1'b0;
      cyc(4);
      // lockout from plain remote: the key must no longer bring it home
      bus(M_MLA);
      bus(M_LLO);
      press();
      check(led, 1);
      ren = 1'b0;
      cyc(5);
      check(led, 0);
      ren = 1'b1;
      cyc(4);
   endtask
   task automatic t_cmds;
      send(12'h421, ERR_REJECT);
      send(12'h622, ERR_REJECT);
      dly = 4'h4;
      send(12'h031, 8'h00);
      send(12'h032, 8'h00);
      bus(M_MLA);
      lonly = 1'b1;
      cyc(8);
      send(12'h834, ERR_REJECT);
      send(12'h438, ERR_REJECT);
      lonly = 1'b0;
      cyc(4);
      send(12'h235, ERR_PROTECT);
      prot = 1'b1;
      cyc(4);
      send(12'h236, 8'h00);
      send(12'h637, 8'h00);
      cyc(8);
      bus(M_GTL);
   endtask
   task automatic t_queue;
      for (int i = 0; i < 3; i++) begin
         rvld = 1'b1;
         rdat = 8'ha0 + 8'(i);
         cyc(1);
         rvld = 1'b0;
         cyc(1);
      end
      for (int i = 0; i < 3; i++) begin
         rd(1, 8'ha0 + 8'(i));
      end
      rd(0, 8'h00);
   endtask
   task automatic t_stb;
      logic [7:0] all_src;
      all_src = (8'h01 << STB_ESB) | (8'h01 << STB_ISCB)
                | (8'h01 << STB_EAV) | (8'h01 << STB_SAV);
      eav = 1'b1;
      cyc(5);
      check(srq, 1);
      check(stb & STB_SUM_MSK, 8'h01 << STB_EAV);
      bus(M_SPL);
      check(srq, 0);
      send(12'h940, 8'h00);
      cyc(6);
      rd(1, 8'h01 << STB_EAV);
      sre_wr = 1'b1;
      cyc(1);
      sre_wr = 1'b0;
      eav = 1'b0;
      cyc(3);
      eav = 1'b1;
      cyc(5);
      check(srq, 0);
      // every source but MAV shows its bit, none enabled so no request
      {esb, iscb, sav} = 3'b111;
      cyc(3);
      check(stb & STB_SUM_MSK, all_src);
      check(srq, 0);
   endtask

   ////////////////////////////////////////
   initial begin
      {resetn, prot, lonly, key_r, pk, cvld, rvld, rreq, sre_wr, eav} = '0;
      {esb, iscb, sav} = 3'b000;
      {ren, lk_seen, msg, cmd, rdat, sre_dat, dly} = {1'b1, 1'b0, 37'h0};
      {fails, n_compared} = '0;
      cyc(8);
      resetn = 1'b1;
      cyc(4);
      t_states();
      t_cmds();
      t_queue();
      t_stb();
      tally_and_finish();
   end
   // the run needs well under a thousand cycles
   initial begin
      #500000;
      fails++;
      tally_and_finish();
   end
endmodule

// [verif/rl_gate_properties.sv]
// Purpose: port-level checks on the command gate
// Assumes: single clock, synchronous active-low reset
// Notes:   pins pass 2-FF synchronisers, hence the deeper past terms
`timescale 1ns/100ps
module rl_gate_properties
   import cmd_gate_pkg::*;
(
   input wire logic       CLK_I,
   input wire logic       RESETN_I,
   input wire logic       PROTECT_SW_I,
   input wire bus_msg_t   BUS_MSG_I,
   input wire logic       CMD_VALID_I,
   input wire cmd_desc_t  CMD_I,
   input wire logic       CMD_READY_O,
   input wire logic       EXEC_VALID_O,
   input wire logic       EXEC_DONE_I,
   input wire logic       READ_REQ_I,
   input wire logic       READ_VALID_O,
   input wire logic       ERR_PUSH_O,
   input wire logic [7:0] ERR_CODE_O,
   input wire logic       REMOTE_LED_O,
   input wire logic       LOCKOUT_MSG_O
);
   default clocking @(posedge CLK_I);
   endclocking
   default disable iff (!RESETN_I);
   wire take = CMD_VALID_I && CMD_READY_O;

   ////////////////////////////////////////
   // a status-byte query is answered through the queue, not the executor
   take_answer_a: assert property (
      take |=> (EXEC_VALID_O ^ ERR_PUSH_O)
      || (!EXEC_VALID_O && !ERR_PUSH_O && $past(CMD_I.is_stb_query)))
      else $error("taken command got no single answer");
   one_at_time_a: assert property (EXEC_VALID_O |-> !CMD_READY_O)
      else $error("ready while a command runs");
   exec_stands_a: assert property (
      EXEC_VALID_O && !EXEC_DONE_I |=> EXEC_VALID_O)
      else $error("command dropped before done");
   local_reject_a: assert property (
      take && CMD_I.is_calcomp && !REMOTE_LED_O && !$past(BUS_MSG_I.mla)
      && !$past(take) |=> ERR_PUSH_O && ERR_CODE_O == ERR_REJECT)
      else $error("cal command not rejected in local");
   protect_err_a: assert property (
      take && CMD_I.is_protected && !CMD_I.is_calcomp && !CMD_I.is_query
      && !PROTECT_SW_I && !$past(PROTECT_SW_I) && !$past(PROTECT_SW_I, 2)
      && !$past(PROTECT_SW_I, 3) |=> ERR_PUSH_O && ERR_CODE_O == ERR_PROTECT)
      else $error("protected command ran with switch off");
   read_cause_a: assert property (READ_VALID_O |-> $past(READ_REQ_I))
      else $error("response sent without a read");
   led_cause_a: assert property (
      $rose(REMOTE_LED_O) |-> $past(BUS_MSG_I.mla, 2) || $past(take, 2))
      else $error("remote lit without listen address");
   gtl_local_a: assert property (
      REMOTE_LED_O && BUS_MSG_I.gtl |=> ##1 !REMOTE_LED_O)
      else $error("go to local ignored");
   lock_msg_a: assert property (LOCKOUT_MSG_O |-> REMOTE_LED_O)
      else $error("lockout message outside remote");
endmodule

bind remote_local_command_gate rl_gate_properties u_props (
   .CLK_I(CLK_I), .RESETN_I(RESETN_I), .PROTECT_SW_I(PROTECT_SW_I),
   .BUS_MSG_I(BUS_MSG_I), .CMD_VALID_I(CMD_VALID_I), .CMD_I(CMD_I),
   .CMD_READY_O(CMD_READY_O), .EXEC_VALID_O(EXEC_VALID_O),
   .EXEC_DONE_I(EXEC_DONE_I), .READ_REQ_I(READ_REQ_I),
   .READ_VALID_O(READ_VALID_O), .ERR_PUSH_O(ERR_PUSH_O),
   .ERR_CODE_O(ERR_CODE_O), .REMOTE_LED_O(REMOTE_LED_O),
   .LOCKOUT_MSG_O(LOCKOUT_MSG_O));
